// ---- sim/sow_chk.sv ----
/* port checker of the switch output controller.
   assumes control writes use all four byte lanes. */
`timescale 1ns/10ps
`include "sow_consts.vh"

module sow_chk (
   input wire clk_i,
   input wire rst_i,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [7:0] wb_adr_i,
   input wire [31:0] wb_dat_i,
   input wire wb_ack_o,
   input wire diag_alarm_i,
   input wire diag_warn_i,
   input wire adv_ch1_i,
   input wire adv_ch2_i,
   input wire error_i,
   input wire switch_closed_o
);
   logic [31:0] ctl_r;
   wire [2:0] fn = ctl_r[2:0];
   wire inv = ctl_r[12];
   wire ev = ctl_r[5:4] == 2'h1 ? diag_alarm_i | diag_warn_i : ctl_r[5:4] == 2'h2 ? diag_warn_i : diag_alarm_i;
   wire ch = ctl_r[17:16] == 2'h1 ? adv_ch1_i : ctl_r[17:16] == 2'h2 ? adv_ch2_i : 1'b0;
   wire subst = (fn == 3'h3 || fn == 3'h4) && error_i && ctl_r[9:8] != 2'h0;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // shadow of the control word at the accepted write
   always @(posedge clk_i) begin
      if (rst_i)
         ctl_r <= `SOW_RST_CTRL;
      else if (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_adr_i == `SOW_ADR_CTRL)
         ctl_r <= wb_dat_i;
   end
   property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
   property p_ack_lat; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
   a_ack_lat: assert property (p_ack_lat) else $error("ack late");
   property p_off; fn == `SOW_FUNC_OFF |=> switch_closed_o == $past(inv); endproperty
   a_off: assert property (p_off) else $error("off mode not open");
   property p_on; fn == `SOW_FUNC_ON |=> switch_closed_o == !$past(inv); endproperty
   a_on: assert property (p_on) else $error("on mode not closed");
   property p_diag; fn == `SOW_FUNC_DIAG |=> switch_closed_o == (!$past(ev) ^ $past(inv)); endproperty
   a_diag: assert property (p_diag) else $error("diag mode wrong");
   property p_dig; fn == `SOW_FUNC_DIGITAL && !error_i |=> switch_closed_o == ($past(ch) ^ $past(inv)); endproperty
   a_dig: assert property (p_dig) else $error("digital mode wrong");
   property p_err; subst |=> switch_closed_o == ($past(ctl_r[9:8] == 2'h2) ^ $past(inv)); endproperty
   a_err: assert property (p_err) else $error("error state wrong");
   property p_lim_none;
      (fn == `SOW_FUNC_LIMIT && ctl_r[27:24] == 4'h0 && !error_i)[*4] |-> switch_closed_o == $past(inv);
   endproperty
   a_lim_none: assert property (p_lim_none) else $error("limit without value not open");
endmodule // sow_chk

bind sow_top sow_chk u_sow_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
   .diag_alarm_i(diag_alarm_i), .diag_warn_i(diag_warn_i), .adv_ch1_i(adv_ch1_i), .adv_ch2_i(adv_ch2_i),
   .error_i(error_i), .switch_closed_o(switch_closed_o));

// ---- sim/sow_load.sv ----
/* external load on the switch contact, seen as a pulled-up sense line.
   assumes switch_closed_o high means the contact conducts. */
`timescale 1ns/10ps

module sow_load (
   input wire closed_i,
   output wire sense_o
);
   // the pull-up wins while the contact is open
   assign sense_o = !closed_i;
endmodule // sow_load

// ---- sim/tb_sow_top.sv ----
/* bench of the switch output controller: bus task, model, scenarios.
   assumes a tenth of a second shortened to four cycles. */
`timescale 1ns/10ps
`include "sow_consts.vh"

module tb_sow_top;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [31:0] wb_dat_i = 32'h0;
   logic [3:0] wb_sel_i = 4'hF;
   logic [3:0] lanes = 4'hF;
   logic [31:0] wb_dat_o;
   logic [383:0] meas_i = 384'h0;
   logic wb_ack_o, sw, sense, q0;
   logic alm = 1'b0, wrn = 1'b0, ch1 = 1'b0, ch2 = 1'b0, err = 1'b0;
   logic [31:0] q;
   int error_cnt = 0, compares = 0, cycles = 0;
   int func, cat, fail, inv, chan, lim, on2, off2, i;

   always #5 clk_i = ~clk_i;

   sow_top #(.TENTH_CYCLES(4)) u_sow_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .meas_i(meas_i), .diag_alarm_i(alm), .diag_warn_i(wrn),
      .adv_ch1_i(ch1), .adv_ch2_i(ch2), .error_i(err), .switch_closed_o(sw));
   sow_load u_sow_load (.closed_i(sw), .sense_o(sense));

   task automatic finish_test();
      if (error_cnt == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // cycle ceiling against a hung run
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 6000) begin
         error_cnt++;
         finish_test();
      end
   end

   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      compares++;
      if (s !== e) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask

   // one classic cycle, held until ack is sampled
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      int n;
      n = 0;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_sel_i <= lanes;
      wb_dat_i <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1);
      r = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      chk("ack_wait", n, 32'h2);
   endtask

   // expected contact state from the bench settings
   function automatic logic model();
      logic s, ev;
      ev = cat == 1 ? alm | wrn : cat == 2 ? wrn : alm;
      case (func)
         1: s = 1'b1;
         2: s = !ev;
         3: s = lim[0];
         4: s = chan == 1 ? ch1 : chan == 2 ? ch2 : 1'b0;
         default: s = 1'b0;
      endcase
      if ((func == 3 || func == 4) && err && fail != 0)
         s = fail == 2;
      return s ^ inv[0];
   endfunction

   task automatic look(input int w);
      repeat (w) @(posedge clk_i);
      q0 = model();
      chk("switch", {31'h0, sw}, {31'h0, q0});
      chk("sense", {31'h0, sense}, {31'h0, !q0});
   endtask

   task automatic set_ctl(input int lsel);
      bus(1'b1, `SOW_ADR_CTRL, 32'(func | cat << 4 | fail << 8 | inv << 12 | chan << 16 | lsel << 24), q);
   endtask

   // limit step: hysteresis model on values scaled by two
   task automatic step(input logic [31:0] h, input int v);
      meas_i[31:0] <= h;
      if (on2 >= off2) begin
         if (v > on2) lim = 1;
         else if (v < off2) lim = 0;
      end else begin
         if (v < on2) lim = 1;
         else if (v > off2) lim = 0;
      end
      look(6);
   endtask

   initial begin
      void'($urandom(32'h5876));
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      for (i = 0; i < 7; i++) begin
         bus(1'b0, 8'(i * 4), 32'h0, q);
         chk("reset", q, i == 0 ? `SOW_RST_CTRL : 32'h0);
      end
      bus(1'b1, `SOW_ADR_ON_VAL, 32'hFFFF_FFFF, q);
      lanes = 4'h5;
      bus(1'b1, `SOW_ADR_ON_VAL, 32'h1234_5678, q);
      lanes = 4'h1;
      bus(1'b1, `SOW_ADR_ON_DLY, 32'h0000_07D0, q);
      lanes = 4'hF;
      bus(1'b0, `SOW_ADR_ON_VAL, 32'h0, q);
      chk("lanes", q, 32'hFF34_FF78);
      bus(1'b0, `SOW_ADR_ON_DLY, 32'h0, q);
      chk("dly_lanes", q, 32'h0000_00D0);
      bus(1'b1, `SOW_ADR_ON_DLY, 32'h0000_07D0, q);
      bus(1'b0, `SOW_ADR_ON_DLY, 32'h0, q);
      chk("clamp", q, 32'h0000_03E8);
      bus(1'b1, `SOW_ADR_ON_DLY, 32'h0, q);
      bus(1'b1, `SOW_ADR_STATUS, 32'hFFFF_FFFF, q);
      bus(1'b0, `SOW_ADR_STATUS, 32'h0, q);
      chk("status", q & 32'h7, 32'h0);
      for (i = 0; i < 48; i++) begin
         func = i % 8;
         cat = (i / 8) % 4;
         fail = (i / 8 + 1) % 4;
         inv = (i / 16) % 2;
         chan = (i / 8 + 2) % 4;
         lim = 0;
         set_ctl(0);
         {alm, wrn, ch1, ch2, err} <= 5'($urandom);
         look(4);
         bus(1'b0, `SOW_ADR_STATUS, 32'h0, q);
         chk("status", q, {27'h0, 2'b00, err & (func == 3 || func == 4), 1'b0, model()});
      end
      func = 3;
      inv = 0;
      fail = 1;
      lim = 0;
      err <= 1'b0;
      on2 = 4;
      off2 = 2;
      meas_i[31:0] <= 32'h3F00_0000;
      bus(1'b1, `SOW_ADR_ON_VAL, 32'h4000_0000, q);
      bus(1'b1, `SOW_ADR_OFF_VAL, 32'h3F80_0000, q);
      set_ctl(1);
      step(32'h4040_0000, 6);
      step(32'h3FC0_0000, 3);
      step(32'h3F00_0000, 1);
      step(32'h3FC0_0000, 3);
      on2 = 2;
      off2 = 4;
      bus(1'b1, `SOW_ADR_OFF_VAL, 32'h4000_0000, q);
      bus(1'b1, `SOW_ADR_ON_VAL, 32'h3F80_0000, q);
      step(32'h3F00_0000, 1);
      step(32'h3FC0_0000, 3);
      step(32'h4040_0000, 6);
      bus(1'b1, `SOW_ADR_ON_DLY, 32'h0000_0002, q);
      bus(1'b1, `SOW_ADR_OFF_DLY, 32'h0000_0002, q);
      meas_i[31:0] <= 32'h3F00_0000;
      bus(1'b0, `SOW_ADR_STATUS, 32'h0, q);
      chk("status", q, 32'h0000_0008);
      look(6);
      lim = 1;
      look(10);
      lim = 0;
      set_ctl(13);
      look(4);
      lim = 1;
      set_ctl(1);
      look(14);
      meas_i[31:0] <= 32'h4040_0000;
      look(5);
      meas_i[31:0] <= 32'h3FC0_0000;
      look(12);
      meas_i[31:0] <= 32'h4040_0000;
      look(6);
      lim = 0;
      look(10);
      inv = 1;
      set_ctl(1);
      look(4);
      bus(1'b0, `SOW_ADR_STATUS, 32'h0, q);
      chk("status", {31'h0, q[0]}, {31'h0, model()});
      finish_test();
   end
endmodule // tb_sow_top

// ---- src/sow_consts.vh ----
/*
 * constants of the switch output controller: register offsets,
 * field positions, reset values, selection codes and timing.
 * assumes inclusion by the files of this block only.
 */
`ifndef SOW_CONSTS_VH
`define SOW_CONSTS_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define SOW_ADR_CTRL 8'h00
`define SOW_ADR_ON_VAL 8'h04
`define SOW_ADR_OFF_VAL 8'h08
`define SOW_ADR_ON_DLY 8'h0C
`define SOW_ADR_OFF_DLY 8'h10
`define SOW_ADR_STATUS 8'h14

// ----------------------------------------------------------------
// control field positions (lsb)
// ----------------------------------------------------------------
`define SOW_FUNC_LSB 0
`define SOW_DIAG_LSB 4
`define SOW_FAIL_LSB 8
`define SOW_INV_BIT 12
`define SOW_CHAN_LSB 16
`define SOW_LIM_LSB 24

// ----------------------------------------------------------------
// selection codes
// ----------------------------------------------------------------
`define SOW_FUNC_OFF 3'h0
`define SOW_FUNC_ON 3'h1
`define SOW_FUNC_DIAG 3'h2
`define SOW_FUNC_LIMIT 3'h3
`define SOW_FUNC_DIGITAL 3'h4
`define SOW_DIAG_ALARM 2'h0
`define SOW_DIAG_ALARM_WARN 2'h1
`define SOW_DIAG_WARN 2'h2
`define SOW_FAIL_ACTUAL 2'h0
`define SOW_FAIL_OPEN 2'h1
`define SOW_FAIL_CLOSED 2'h2
`define SOW_CHAN_OFF 2'h0
`define SOW_CHAN_1 2'h1
`define SOW_CHAN_2 2'h2
`define SOW_LIM_OFF 4'h0
`define SOW_LIM_LAST 4'hC

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define SOW_RST_CTRL 32'h0000_0100
`define SOW_RST_VAL 32'h0000_0000
`define SOW_RST_DLY 11'h000

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SOW_CLK_NS 10
`define SOW_TENTH_NS 100000000
`define SOW_DLY_MAX 11'h3E8

`endif

// ---- src/sow_dly.v ----
/*
 * qualification timer: done rises once req_i has stood for
 * dly_i tenths of a second; any drop of req_i restarts it.
 * assumes dly_i is stable while the timer runs.
 */
`timescale 1ns/10ps

module sow_dly #(
   parameter TENTH_CYCLES = 10000000
) (
   input wire clk_i,
   input wire rst_i,
   input wire req_i,
   input wire [10:0] dly_i,
   output reg done_o,
   output wire busy_o
);

   reg [23:0] pre_r;
   reg [10:0] cnt_r;
   wire pre_end;

   assign pre_end = (pre_r == TENTH_CYCLES[23:0] - 24'h00_0001);
   assign busy_o = req_i & ~done_o;

   // ----------------------------------------------------------------
   // tenth prescaler and tenth counter
   // ----------------------------------------------------------------
   always @(posedge clk_i) begin
      if (rst_i || !req_i) begin
         pre_r <= 24'h00_0000;
         cnt_r <= 11'h000;
         done_o <= 1'b0;
      end else if (cnt_r >= dly_i) begin
         done_o <= 1'b1;
      end else if (pre_end) begin
         pre_r <= 24'h00_0000;
         cnt_r <= cnt_r + 11'h001;
      end else begin
         pre_r <= pre_r + 24'h00_0001;
      end
   end

endmodule // sow_dly

// ---- src/sow_fcmp.v ----
/*
 * signed single precision float comparator, a against b.
 * assumes ordinary numbers; +0 and -0 compare equal, nan not handled.
 */
`timescale 1ns/10ps

module sow_fcmp (
   input wire [31:0] a_i,
   input wire [31:0] b_i,
   output reg gt_o,
   output reg lt_o
);

   // ----------------------------------------------------------------
   // sign magnitude ordering
   // ----------------------------------------------------------------
   always @* begin
      gt_o = 1'b0;
      lt_o = 1'b0;
      if ((a_i[30:0] == 31'h0000_0000) && (b_i[30:0] == 31'h0000_0000)) begin
         gt_o = 1'b0; // both zero
      end else if (a_i[31] != b_i[31]) begin
         gt_o = b_i[31];
         lt_o = a_i[31];
      end else if (a_i[31]) begin
         gt_o = a_i[30:0] < b_i[30:0]; // both negative
         lt_o = a_i[30:0] > b_i[30:0];
      end else begin
         gt_o = a_i[30:0] > b_i[30:0];
         lt_o = a_i[30:0] < b_i[30:0];
      end
   end

endmodule // sow_fcmp

// ---- src/sow_top.v ----
/*
 * switch output controller: drives one switch contact from a
 * selected function, with wishbone classic register access.
 * assumes measured values, diagnostic events, channel levels and
 * the error flag come from logic on clk_i; thresholds and values
 * are single precision floats.
 */
// The Wishbone slave port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
`include "sow_consts.vh"

module sow_top #(
   parameter TENTH_CYCLES = `SOW_TENTH_NS / `SOW_CLK_NS
) (
   input wire clk_i,
   input wire rst_i,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [7:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   input wire [383:0] meas_i,
   input wire diag_alarm_i,
   input wire diag_warn_i,
   input wire adv_ch1_i,
   input wire adv_ch2_i,
   input wire error_i,
   output reg switch_closed_o
);

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   reg [31:0] ctrl_r;
   reg [31:0] on_val_r;
   reg [31:0] off_val_r;
   reg [10:0] on_dly_r;
   reg [10:0] off_dly_r;
   reg lim_r;
   reg lim_nxt;
   reg comp_nxt;
   reg sub_nxt;
   reg event_sel;
   reg [31:0] rd_nxt;
   wire [31:0] wmask;
   wire [31:0] dly_wr;
   wire [10:0] dly_clamp;
   wire req;
   wire wr_stb;
   wire [2:0] func;
   wire [1:0] diag_sel;
   wire [1:0] fail_sel;
   wire [1:0] chan_sel;
   wire [3:0] lim_sel;
   wire invert;
   wire lim_en;
   wire [3:0] lim_idx;
   wire [31:0] val;
   wire v_gt_on;
   wire v_lt_on;
   wire v_gt_off;
   wire v_lt_off;
   wire on_gt_off;
   wire on_lt_off;
   wire cond_close;
   wire cond_open;
   wire close_done;
   wire open_done;
   wire close_busy;
   wire open_busy;
   wire err_apply;

   // ----------------------------------------------------------------
   // bus decode
   // ----------------------------------------------------------------

   // request seen in its first cycle only, answer one cycle later;
   // a write lands on the edge at which the master samples ack
   assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr_stb = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
   assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

   // delay write: unselected lanes zeroed, then limited to 100.0 s
   assign dly_wr = wb_dat_i & wmask;
   assign dly_clamp = (dly_wr > {21'h00_0000, `SOW_DLY_MAX}) ? `SOW_DLY_MAX : dly_wr[10:0];

   // ----------------------------------------------------------------
   // control fields
   // ----------------------------------------------------------------
   // slices of the control word
   assign func = ctrl_r[`SOW_FUNC_LSB +: 3];
   assign diag_sel = ctrl_r[`SOW_DIAG_LSB +: 2];
   assign fail_sel = ctrl_r[`SOW_FAIL_LSB +: 2];
   assign chan_sel = ctrl_r[`SOW_CHAN_LSB +: 2];
   assign lim_sel = ctrl_r[`SOW_LIM_LSB +: 4];
   assign invert = ctrl_r[`SOW_INV_BIT];

   // ----------------------------------------------------------------
   // register writes
   // ----------------------------------------------------------------

   always @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_r <= `SOW_RST_CTRL;
         on_val_r <= `SOW_RST_VAL;
         off_val_r <= `SOW_RST_VAL;
         on_dly_r <= `SOW_RST_DLY;
         off_dly_r <= `SOW_RST_DLY;
      end else if (wr_stb) begin
         case (wb_adr_i)
            `SOW_ADR_CTRL: begin
               ctrl_r <= (ctrl_r & ~wmask) | (wb_dat_i & wmask);
            end
            `SOW_ADR_ON_VAL: begin
               on_val_r <= (on_val_r & ~wmask) | (wb_dat_i & wmask);
            end
            `SOW_ADR_OFF_VAL: begin
               off_val_r <= (off_val_r & ~wmask) | (wb_dat_i & wmask);
            end
            `SOW_ADR_ON_DLY: begin
               on_dly_r <= dly_clamp;
            end
            `SOW_ADR_OFF_DLY: begin
               off_dly_r <= dly_clamp;
            end
            default: begin
               ctrl_r <= ctrl_r; // unmapped or read only
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // register reads
   // ----------------------------------------------------------------

   always @* begin
      rd_nxt = 32'h0000_0000;
      case (wb_adr_i)
         `SOW_ADR_CTRL: rd_nxt = ctrl_r;
         `SOW_ADR_ON_VAL: rd_nxt = on_val_r;
         `SOW_ADR_OFF_VAL: rd_nxt = off_val_r;
         `SOW_ADR_ON_DLY: rd_nxt = {21'h00_0000, on_dly_r};
         `SOW_ADR_OFF_DLY: rd_nxt = {21'h00_0000, off_dly_r};
         `SOW_ADR_STATUS: begin
            rd_nxt = {27'h000_0000, open_busy, close_busy, err_apply, lim_r, switch_closed_o};
         end
         default: rd_nxt = 32'h0000_0000;
      endcase
   end

   // ack and read data, unmapped addresses answer zero
   always @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= req;
         if (req && !wb_we_i) begin
            wb_dat_o <= rd_nxt;
         end
      end
   end

   // ----------------------------------------------------------------
   // limit comparator
   // ----------------------------------------------------------------

   // pick one of twelve values, code zero is none
   assign lim_en = (lim_sel != `SOW_LIM_OFF) && (lim_sel <= `SOW_LIM_LAST);
   assign lim_idx = lim_en ? (lim_sel - 4'h1) : 4'h0;
   assign val = meas_i[{lim_idx, 5'h00} +: 32];

   // value against each threshold, then threshold order
   sow_fcmp u_cmp_on (
      .a_i(val),
      .b_i(on_val_r),
      .gt_o(v_gt_on),
      .lt_o(v_lt_on)
   );

   sow_fcmp u_cmp_off (
      .a_i(val),
      .b_i(off_val_r),
      .gt_o(v_gt_off),
      .lt_o(v_lt_off)
   );

   sow_fcmp u_cmp_thr (
      .a_i(on_val_r),
      .b_i(off_val_r),
      .gt_o(on_gt_off),
      .lt_o(on_lt_off)
   );

   assign cond_close = on_lt_off ? v_lt_on : v_gt_on;
   assign cond_open = on_lt_off ? v_gt_off : v_lt_off;

   // ----------------------------------------------------------------
   // qualification timers
   // ----------------------------------------------------------------

   sow_dly #(
      .TENTH_CYCLES(TENTH_CYCLES)
   ) u_dly_on (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .req_i(lim_en & ~lim_r & cond_close),
      .dly_i(on_dly_r),
      .done_o(close_done),
      .busy_o(close_busy)
   );

   sow_dly #(
      .TENTH_CYCLES(TENTH_CYCLES)
   ) u_dly_off (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .req_i(lim_en & lim_r & cond_open),
      .dly_i(off_dly_r),
      .done_o(open_done),
      .busy_o(open_busy)
   );

   // ----------------------------------------------------------------
   // limit state with hysteresis
   // ----------------------------------------------------------------

   always @* begin
      lim_nxt = lim_r;
      if (!lim_en) begin
         lim_nxt = 1'b0; // no value assigned: open
      end else if (!lim_r && close_done) begin
         lim_nxt = 1'b1;
      end else if (lim_r && open_done) begin
         lim_nxt = 1'b0;
      end
   end

   // limit state register
   always @(posedge clk_i) begin
      if (rst_i) begin
         lim_r <= 1'b0;
      end else begin
         lim_r <= lim_nxt;
      end
   end

   // ----------------------------------------------------------------
   // function selection
   // ----------------------------------------------------------------

   always @* begin
      case (diag_sel)
         `SOW_DIAG_ALARM_WARN: event_sel = diag_alarm_i | diag_warn_i;
         `SOW_DIAG_WARN: event_sel = diag_warn_i;
         default: event_sel = diag_alarm_i; // alarm and spare code
      endcase
   end

   // computed contact state before error and inversion
   always @* begin
      case (func)
         `SOW_FUNC_OFF: comp_nxt = 1'b0;
         `SOW_FUNC_ON: comp_nxt = 1'b1;
         `SOW_FUNC_DIAG: comp_nxt = ~event_sel;
         `SOW_FUNC_LIMIT: comp_nxt = lim_r;
         `SOW_FUNC_DIGITAL: begin
            case (chan_sel)
               `SOW_CHAN_1: comp_nxt = adv_ch1_i;
               `SOW_CHAN_2: comp_nxt = adv_ch2_i;
               default: comp_nxt = 1'b0; // no channel: open
            endcase
         end
         default: comp_nxt = 1'b0; // spare codes act as off
      endcase
   end

   // ----------------------------------------------------------------
   // error substitution
   // ----------------------------------------------------------------

   // error state only in limit or digital mode
   assign err_apply = error_i & ((func == `SOW_FUNC_LIMIT) | (func == `SOW_FUNC_DIGITAL));

   // substitute the error state, actual keeps the computed one
   always @* begin
      sub_nxt = comp_nxt;
      if (err_apply) begin
         case (fail_sel)
            `SOW_FAIL_ACTUAL: sub_nxt = comp_nxt;
            `SOW_FAIL_CLOSED: sub_nxt = 1'b1;
            default: sub_nxt = 1'b0; // open and spare code
         endcase
      end
   end

   // ----------------------------------------------------------------
   // output stage
   // ----------------------------------------------------------------

   // inversion last, one flop drives contact
   always @(posedge clk_i) begin
      if (rst_i) begin
         switch_closed_o <= 1'b0;
      end else begin
         switch_closed_o <= sub_nxt ^ invert;
      end
   end

endmodule // sow_top
